// [core/sbrg_pkg.sv]
// package: register map, field layout, reset values of the baud generator
package sbrg_pkg;

  // ===========================================================================
  // register byte offsets
  localparam logic [7:0] SBRG_OFF_DIV_HIGH = 8'h00;
  localparam logic [7:0] SBRG_OFF_DIV_LOW  = 8'h04;
  localparam logic [7:0] SBRG_OFF_CTRL_TWO = 8'h08;
  localparam logic [7:0] SBRG_OFF_STATUS   = 8'h0C;
  localparam logic [7:0] SBRG_OFF_MASK     = 8'h10;

  // ===========================================================================
  // field positions
  localparam int SBRG_HIGH_LBK_IE_BIT = 7;
  localparam int SBRG_HIGH_RXE_IE_BIT = 6;
  localparam int SBRG_HIGH_DIV_MSB    = 4;
  localparam int SBRG_CTRL_TE_BIT     = 3;
  localparam int SBRG_CTRL_RE_BIT     = 2;
  localparam int SBRG_STAT_LBK_BIT    = 0;
  localparam int SBRG_STAT_RXE_BIT    = 1;
  localparam int SBRG_DIV_WIDTH       = 13;
  localparam int SBRG_OVERSAMPLE      = 16;

  // ===========================================================================
  // reset values
  localparam logic [7:0] SBRG_RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] SBRG_RST_DIV_LOW  = 8'h04;
  localparam logic [7:0] SBRG_RST_CTRL_TWO = 8'h00;
  localparam logic [1:0] SBRG_RST_MASK     = 2'h0;

  // ===========================================================================
  // axi responses
  localparam logic [1:0] SBRG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SBRG_RESP_SLVERR = 2'h2;

endpackage

// [core/sbrg_tick_gen.sv]
// divider: down-counter emitting one tick per divisor, then by sixteen
`timescale 1ns/1ps
module sbrg_tick_gen
  import sbrg_pkg::*;
#(
  parameter int DIV_W = SBRG_DIV_WIDTH
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick_x16,
  output logic                  tick_baud
);

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic [3:0]       phase;
    logic             tick_x16;
    logic             tick_baud;
  } sbrg_tick_state_t;

  sbrg_tick_state_t st_reg;
  sbrg_tick_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick_x16 = 1'b0;
    st_next.tick_baud = 1'b0;
    // zero divisor or idle: counter and phase cleared and held at zero, no ticks, saves power
    if (!run || divisor == '0) begin // R4
      st_next.count = '0;
      st_next.phase = '0;
    end else if (st_reg.count <= DIV_W'(1)) begin // R10
      st_next.count = divisor;
      st_next.tick_x16 = 1'b1;
      st_next.phase = st_reg.phase + 4'h1; // R5
      st_next.tick_baud = (st_reg.phase == 4'hF);
    end else begin
      st_next.count = st_reg.count - DIV_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_x16  = st_reg.tick_x16;
  assign tick_baud = st_reg.tick_baud;

endmodule

// [core/sbrg_top.sv]
// top: axi4-lite register file and shared baud generator of one serial unit
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

// Summary of operation
// R1: software writes the divisor high half first, then the low half.
// R2: high write only buffers; low write loads both halves into use.
// R3: divisor 12:8 in high bits 4:0, divisor 7:0 fill low register.
// R4: a zero divisor stops the generator, no ticks are produced.
// R5: nonzero divisor gives baud equal to clock over sixteen times divisor.
// R6: low half resets nonzero; generator idle until an enable is set.
// R7: transmitter and receiver share one generator; each unit has its own.
// R8: high bit 7 set requests an interrupt while the line-break flag is one.
// R9: high bit 6 set requests an interrupt while the receive-edge flag is one.
// R10: down-counter reloaded with divisor emits a one-cycle x16 tick.
module sbrg_top
  import sbrg_pkg::*;
#(
  parameter int DIV_W = SBRG_DIV_WIDTH
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // event pulses from receiver logic
  input  wire logic        line_break_event,
  input  wire logic        rx_edge_event,
  // shared timing to transmitter and receiver
  output logic             tick_x16,
  output logic             tick_baud,
  output logic             receiver_enable,
  output logic             transmitter_enable,
  // interrupt request
  output logic             irq
);

  // ===========================================================================
  // state
  typedef struct packed {
    // register file
    logic [7:0]       high_buf;
    logic [7:0]       low_reg;
    logic [DIV_W-1:0] baud_divisor;
    logic [7:0]       ctrl_two;
    logic             gen_armed;
    // interrupt flags and enables
    logic [1:0]       status;
    logic [1:0]       mask;
    // write channel capture
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    // response registers
    logic             bvalid;
    logic [1:0]       bresp;
    // read channel
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sbrg_state_t;

  sbrg_state_t st_reg;
  sbrg_state_t st_next;

  // ===========================================================================
  // reset image of the whole state
  localparam sbrg_state_t SBRG_STATE_RESET = '{
    high_buf:     SBRG_RST_DIV_HIGH,
    low_reg:      SBRG_RST_DIV_LOW, // R6
    baud_divisor: DIV_W'({SBRG_RST_DIV_HIGH[SBRG_HIGH_DIV_MSB:0],
                          SBRG_RST_DIV_LOW}),
    ctrl_two:     SBRG_RST_CTRL_TWO,
    gen_armed:    1'b0, // R6
    status:       2'h0,
    mask:         SBRG_RST_MASK,
    aw_held:      1'b0,
    aw_addr:      8'h00,
    w_held:       1'b0,
    w_data:       32'h0000_0000,
    w_strb:       4'h0,
    bvalid:       1'b0,
    bresp:        SBRG_RESP_OKAY,
    rvalid:       1'b0,
    rdata:        32'h0000_0000,
    rresp:        SBRG_RESP_OKAY
  };

  // offsets that answer OKAY; all others answer SLVERR
  function automatic logic sbrg_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      SBRG_OFF_DIV_HIGH,
      SBRG_OFF_DIV_LOW,
      SBRG_OFF_CTRL_TWO,
      SBRG_OFF_STATUS,
      SBRG_OFF_MASK: begin
        hit = 1'b1;
      end
      default: begin
      end
    endcase
    return hit;
  endfunction

  // ===========================================================================
  // helpers
  // response code of a transfer at this offset
  function automatic logic [1:0] sbrg_resp(input logic [7:0] addr);
    if (sbrg_mapped(addr)) begin
      return SBRG_RESP_OKAY;
    end
    return SBRG_RESP_SLVERR;
  endfunction

  // bit 5 is reserved and always reads zero
  function automatic logic [7:0] sbrg_high_keep(input logic [7:0] wr);
    return wr & 8'hDF;
  endfunction

  // working divisor from the buffered high half and the new low half
  function automatic logic [DIV_W-1:0] sbrg_join_divisor(
    input logic [7:0] high,
    input logic [7:0] low
  );
    return DIV_W'({high[SBRG_HIGH_DIV_MSB:0], low});
  endfunction

  // either side enabled arms the generator for good
  function automatic logic sbrg_arms(input logic [7:0] ctrl);
    return ctrl[SBRG_CTRL_TE_BIT] || ctrl[SBRG_CTRL_RE_BIT];
  endfunction

  // one interrupt source: its enable bit gates its sticky flag
  function automatic logic sbrg_irq_src(
    input logic enable,
    input logic flag
  );
    return enable && flag;
  endfunction

  // sticky flags: a clearing read loses to an event in the same cycle
  function automatic logic [1:0] sbrg_flags(
    input logic [1:0] flags,
    input logic       clear,
    input logic [1:0] set
  );
    logic [1:0] kept;
    kept = clear ? 2'h0 : flags;
    return kept | set;
  endfunction

  // read data of one register, zero-extended; unmapped offsets read zero
  function automatic logic [31:0] sbrg_read_word(
    input logic [7:0]  addr,
    input sbrg_state_t st
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    unique case (addr)
      SBRG_OFF_DIV_HIGH: begin
        word[7:0] = st.high_buf;
      end
      SBRG_OFF_DIV_LOW: begin
        word[7:0] = st.low_reg;
      end
      SBRG_OFF_CTRL_TWO: begin
        word[7:0] = st.ctrl_two;
      end
      SBRG_OFF_STATUS: begin
        word[1:0] = st.status;
      end
      SBRG_OFF_MASK: begin
        word[1:0] = st.mask;
      end
      default: begin
      end
    endcase
    return word;
  endfunction

  logic       do_write;
  logic       do_read;
  logic       aw_take;
  logic       w_take;
  logic       b_done;
  logic       r_done;
  logic       wr_lane0;
  logic       arm_req;
  logic       rd_status;
  logic [7:0] wr_byte;
  logic [1:0] flag_set;
  logic       irq_break;
  logic       irq_edge;
  logic       irq_masked;

  // ===========================================================================
  // channel decode
  assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign b_done        = st_reg.bvalid && s_axi_bready;
  assign r_done        = st_reg.rvalid && s_axi_rready;
  assign do_write      = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;
  // a clear lane 0 still answers, but changes no register
  assign wr_lane0      = do_write && st_reg.w_strb[0];
  assign wr_byte       = st_reg.w_data[7:0];
  assign arm_req       = sbrg_arms(wr_byte);
  assign rd_status     = do_read && s_axi_araddr == SBRG_OFF_STATUS;
  assign flag_set      = {rx_edge_event, line_break_event};

  // ===========================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    // capture of address and data, in either order
    if (aw_take) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    // responses retire on the master's ready
    if (b_done) begin
      st_next.bvalid = 1'b0;
    end
    if (r_done) begin
      st_next.rvalid = 1'b0;
    end

    // commit of a fully captured write
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = sbrg_resp(st_reg.aw_addr);
      // register updates on byte lane 0
      if (wr_lane0) begin
        unique case (st_reg.aw_addr)
          SBRG_OFF_DIV_HIGH: begin
            // buffered only; working divisor untouched
            st_next.high_buf = sbrg_high_keep(wr_byte); // R2
          end
          SBRG_OFF_DIV_LOW: begin
            st_next.low_reg = wr_byte;
            st_next.baud_divisor = sbrg_join_divisor(st_reg.high_buf,
                                                     wr_byte); // R2 R3
          end
          SBRG_OFF_CTRL_TWO: begin
            st_next.ctrl_two = wr_byte;
            if (arm_req) begin
              st_next.gen_armed = 1'b1; // R6
            end
          end
          SBRG_OFF_MASK: begin
            st_next.mask = wr_byte[1:0];
          end
          default: begin
          end
        endcase
      end
    end

    // read answers one cycle after the address
    if (do_read) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = sbrg_resp(s_axi_araddr);
      st_next.rdata  = sbrg_read_word(s_axi_araddr, st_reg);
    end

    // sticky flags last, so that an event is never lost to a read
    st_next.status = sbrg_flags(st_reg.status, rd_status, flag_set);
  end

  // ===========================================================================
  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= SBRG_STATE_RESET; // R6
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================================
  // one generator shared by transmitter and receiver of this unit
  sbrg_tick_gen #(
    .DIV_W (DIV_W)
  ) u_tick_gen (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .run       (st_reg.gen_armed),
    .divisor   (st_reg.baud_divisor),
    .tick_x16  (tick_x16),
    .tick_baud (tick_baud)
  ); // R7

  // ===========================================================================
  // outputs
  // data outputs straight from flip-flops
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata  = st_reg.rdata;
  assign s_axi_rresp  = st_reg.rresp;

  assign receiver_enable    = st_reg.ctrl_two[SBRG_CTRL_RE_BIT];
  assign transmitter_enable = st_reg.ctrl_two[SBRG_CTRL_TE_BIT];

  // enable bits in the high register gate the flags; mask register too
  assign irq_break  = sbrg_irq_src(st_reg.high_buf[SBRG_HIGH_LBK_IE_BIT],
                                   st_reg.status[SBRG_STAT_LBK_BIT]); // R8
  assign irq_edge   = sbrg_irq_src(st_reg.high_buf[SBRG_HIGH_RXE_IE_BIT],
                                   st_reg.status[SBRG_STAT_RXE_BIT]); // R9
  assign irq_masked = |(st_reg.status & st_reg.mask);
  assign irq        = irq_break || irq_edge || irq_masked;

endmodule

// [testbench/sbrg_top_props.sv]
// checker: handshake, tick and enable properties of sbrg_top
`timescale 1ns/1ps
module sbrg_top_props
  import sbrg_pkg::*;
(
  input logic        ref_clk,
  input logic        reset_n,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        tick_x16,
  input logic        tick_baud,
  input logic        receiver_enable,
  input logic        transmitter_enable,
  input logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic       armed_reg, seen_reg;
  logic [4:0] cnt_reg;
  // any write activity may restart the divider, so drop the interval
  wire bus_w = (s_axi_awvalid & s_axi_awready) |
               (s_axi_wvalid & s_axi_wready) | s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
      seen_reg  <= 1'b0;
      cnt_reg   <= 5'h0;
    end else begin
      armed_reg <= armed_reg | receiver_enable | transmitter_enable;
      seen_reg  <= bus_w ? 1'b0 : (seen_reg | tick_baud);
      cnt_reg   <= tick_baud ? 5'h0 : cnt_reg + 5'(tick_x16);
    end
  end
  // ==========================================
  // properties
  chk_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while data pending");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  chk_b_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_idle_unarmed: assert property (tick_x16 |-> armed_reg)
    else $error("tick before any enable");
  chk_baud_sixteen: assert property (tick_baud && seen_reg |->
    cnt_reg + tick_x16 == 16) else $error("baud tick not every sixteen");
  cover property (tick_baud);
  cover property (irq);
  cover property (s_axi_bvalid && s_axi_bresp == SBRG_RESP_SLVERR);
endmodule
bind sbrg_top sbrg_top_props u_props (.*);

// [testbench/sbrg_line_model.sv]
// partner: far-side line events and baud tick count
`timescale 1ns/1ps
module sbrg_line_model (
  input  logic ref_clk,
  input  logic reset_n,
  input  logic tick_baud,
  input  logic brk,
  input  logic edg,
  output logic line_break_event,
  output logic rx_edge_event,
  output int   bauds
);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_break_event <= 1'b0;
      rx_edge_event    <= 1'b0;
      bauds            <= 0;
    end else begin
      line_break_event <= brk;
      rx_edge_event    <= edg;
      bauds            <= bauds + tick_baud;
    end
  end
endmodule

// [testbench/sbrg_top_tb.sv]
// testbench: registers, divisor loading, tick rates, interrupts
`timescale 1ns/1ps
module sbrg_top_tb
  import sbrg_pkg::*;
;
  logic        ref_clk = 0, reset_n = 0, brk = 0, edg = 0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, line_break_event, rx_edge_event, tick_x16;
  logic        tick_baud, receiver_enable, transmitter_enable, irq;
  int          errors = 0, comparisons = 0, x16s = 0, bauds, n, d;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) x16s += tick_x16;
  sbrg_top uut (.*);
  sbrg_line_model u_line (.*);
  // ==========================================
  // tasks
  function automatic logic [31:0] hi_rd(logic [7:0] w);
    return {24'h0, w & 8'hdf};
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] dat);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dat;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // skips two ticks so a reload in flight does not skew the period
  task automatic per(bit b);
    n = 0;
    repeat (2) do @(posedge ref_clk); while (!(b ? tick_baud : tick_x16));
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(b ? tick_baud : tick_x16));
  endtask
  task automatic fire(int i);
    brk <= (i == 0);
    edg <= (i == 1);
    @(posedge ref_clk);
    brk <= 0;
    edg <= 0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    errors++;
    complete_run;
  end
  // ==========================================
  // tests
  initial begin
    void'($urandom(32'h8c48_f715));
    repeat (5) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    rd(SBRG_OFF_DIV_LOW);
    chk("low reset", v, 32'h0000_0004);
    rd(8'h14);
    chk("unmapped rd", r, SBRG_RESP_SLVERR);
    wr(8'h14, 32'h0000_00ff);
    chk("unmapped wr", r, SBRG_RESP_SLVERR);
    d = $urandom_range(40, 3);
    wr(SBRG_OFF_DIV_LOW, d);
    repeat (50) @(posedge ref_clk);
    chk("idle ticks", x16s, 0);
    for (int i = SBRG_CTRL_RE_BIT; i <= SBRG_CTRL_TE_BIT; i++) begin
      wr(SBRG_OFF_CTRL_TWO, 1 << i);
      chk("enable", {transmitter_enable, receiver_enable}, 1 << i - 2);
    end
    per(0);
    chk("x16 period", n, d);
    per(1);
    chk("baud period", n, SBRG_OVERSAMPLE * d);
    $display("test rate done");
    wr(SBRG_OFF_DIV_HIGH, 32'h0000_003f);
    per(0);
    chk("high buffered", n, d);
    rd(SBRG_OFF_DIV_HIGH);
    chk("high read", v, hi_rd(8'h3f));
    wr(SBRG_OFF_DIV_LOW, 32'h0000_00ff);
    per(0);
    chk("max divisor", n, 8191);
    wr(SBRG_OFF_DIV_HIGH, 0);
    wr(SBRG_OFF_DIV_LOW, 0);
    repeat (2) @(posedge ref_clk);
    n = x16s;
    d = bauds;
    repeat (300) @(posedge ref_clk);
    chk("stopped x16", x16s - n, 0);
    chk("stopped baud", bauds - d, 0);
    $display("test divisor done");
    for (int i = 0; i < 2; i++) begin
      fire(i);
      chk("irq off", irq, 0);
      wr(SBRG_OFF_DIV_HIGH, i ? 32'h0000_0040 : 32'h0000_0080);
      chk("irq on", irq, 1);
      rd(SBRG_OFF_STATUS);
      chk("status", v, 1 << i);
      chk("irq cleared", irq, 0);
      wr(SBRG_OFF_DIV_HIGH, 0);
      wr(SBRG_OFF_MASK, 1 << i);
      fire(i);
      chk("irq masked", irq, 1);
      rd(SBRG_OFF_STATUS);
      wr(SBRG_OFF_MASK, 0);
    end
    $display("test irq done");
    complete_run;
  end
endmodule
